// *** core/ppc_pad_config.v ***
// Pad configuration register file with APB slave and pad qualification
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module ppc_pad_config #(
	parameter SMALL_MEMORY = 0
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        rst_b,
	input  wire        clkEn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// Peripheral outputs to be routed
	input  wire        spi1Out,
	input  wire        spi2Out,
	input  wire [9:0]  capCmpOut,
	input  wire        ser1Out,
	input  wire        ser2Out,
	// Peripheral pad controls
	output wire        spi1PadOut,
	output wire        spi1PadOe,
	output wire        spi2PadOut,
	output wire        spi2PadOe,
	output wire [9:0]  capCmpPadOut,
	output wire [9:0]  capCmpPadOe,
	output wire        ser1PadOut,
	output wire        ser1PadOe,
	output wire        ser2PadOut,
	output wire        ser2PadOe,
	// Pulse-delay input
	input  wire        portFPin1In,
	output wire        pulseDelayIn,
	// Port pull-up enables
	output wire        portBPullup,
	output wire        portDPullup,
	output wire        portEPullup,
	output wire        portJPullup,
	// Analog selects
	output wire [23:0] analogSelect,
	// Generic port
	input  wire [7:0]  portPinIn,
	output wire [7:0]  portPadOut,
	output wire [7:0]  portPadOe,
	output wire [7:0]  portPadPullup
);
	reg  [7:0] odc1_ff;
	reg  [7:0] odc2_ff;
	reg  [7:0] odc3_ff;
	reg  [7:0] padCfg_ff;
	reg  [7:0] intCtl2_ff;
	reg  [7:0] ansel0_ff;
	reg  [7:0] ansel1_ff;
	reg  [7:0] ansel2_ff;
	reg  [7:0] dir_ff;
	reg  [7:0] latch_ff;
	reg  [7:0] nxt_odc1;
	reg  [7:0] nxt_odc2;
	reg  [7:0] nxt_odc3;
	reg  [7:0] nxt_padCfg;
	reg  [7:0] nxt_intCtl2;
	reg  [7:0] nxt_ansel0;
	reg  [7:0] nxt_ansel1;
	reg  [7:0] nxt_ansel2;
	reg  [7:0] nxt_dir;
	reg  [7:0] nxt_latch;
	reg  [31:0] nxt_prdata;
	wire       wrEn;
	wire       rdEn;
	wire       addrHit;
	wire [7:0] wByte;
	wire [7:0] odc2Mask;
	wire [9:0] ccOdEn;
	wire       selOdc1;
	wire       selOdc2;
	wire       selOdc3;
	wire       selPadCfg;
	wire       selIntCtl2;
	wire       selAnsel0;
	wire       selAnsel1;
	wire       selAnsel2;
	wire       selDir;
	wire       selLatch;
	wire       selPins;

	// Masked write keeps unimplemented bits at zero
	function [7:0] maskedByte;
		input [7:0] data;
		input [7:0] mask;
		begin
			maskedByte = data & mask;
		end
	endfunction

	// Open-drain pad: drives low only
	function odOe;
		input odEn;
		input val;
		begin
			odOe = ~(odEn & val);
		end
	endfunction

	// Register select from the byte address
	function offsetHit;
		input [11:0] addr;
		input [11:0] offset;
		begin
			offsetHit = (addr == offset);
		end
	endfunction

	assign odc2Mask = (SMALL_MEMORY != 0) ? `PPC_ODC2_MASK32K : `PPC_ODC2_MASK;
	assign wByte    = pwdata[7:0];
	assign pready   = 1'b1;
	assign selOdc1    = offsetHit(paddr, `PPC_OFF_ODC1);
	assign selOdc2    = offsetHit(paddr, `PPC_OFF_ODC2);
	assign selOdc3    = offsetHit(paddr, `PPC_OFF_ODC3);
	assign selPadCfg  = offsetHit(paddr, `PPC_OFF_PADCFG);
	assign selIntCtl2 = offsetHit(paddr, `PPC_OFF_INTCTL2);
	assign selAnsel0  = offsetHit(paddr, `PPC_OFF_ANSEL0);
	assign selAnsel1  = offsetHit(paddr, `PPC_OFF_ANSEL1);
	assign selAnsel2  = offsetHit(paddr, `PPC_OFF_ANSEL2);
	assign selDir     = offsetHit(paddr, `PPC_OFF_DIR);
	assign selLatch   = offsetHit(paddr, `PPC_OFF_LATCH);
	assign selPins    = offsetHit(paddr, `PPC_OFF_PINS);
	assign addrHit  = selOdc1 | selOdc2 | selOdc3 | selPadCfg | selIntCtl2 | selAnsel0 |
		selAnsel1 | selAnsel2 | selDir | selLatch | selPins;
	assign pslverr  = psel & penable & ~addrHit;
	assign wrEn     = psel & penable & pwrite & clkEn;
	assign rdEn     = psel & penable & ~pwrite & clkEn;

	// Next register values from a bus write
	always @* begin
		nxt_odc1    = odc1_ff;
		nxt_odc2    = odc2_ff;
		nxt_odc3    = odc3_ff;
		nxt_padCfg  = padCfg_ff;
		nxt_intCtl2 = intCtl2_ff;
		nxt_ansel0  = ansel0_ff;
		nxt_ansel1  = ansel1_ff;
		nxt_ansel2  = ansel2_ff;
		nxt_dir     = dir_ff;
		nxt_latch   = latch_ff;
		if (wrEn) begin
			case (paddr)
				`PPC_OFF_ODC1: begin
					nxt_odc1 = maskedByte(wByte, `PPC_ODC1_MASK);
				end
				`PPC_OFF_ODC2: begin
					nxt_odc2 = maskedByte(wByte, odc2Mask);
				end
				`PPC_OFF_ODC3: begin
					nxt_odc3 = maskedByte(wByte, `PPC_ODC3_MASK);
				end
				`PPC_OFF_PADCFG: begin
					nxt_padCfg = maskedByte(wByte, `PPC_PADCFG_MASK);
				end
				`PPC_OFF_INTCTL2: begin
					nxt_intCtl2 = maskedByte(wByte, `PPC_INTCTL2_MASK);
				end
				`PPC_OFF_ANSEL0: begin
					nxt_ansel0 = wByte;
				end
				`PPC_OFF_ANSEL1: begin
					nxt_ansel1 = wByte;
				end
				`PPC_OFF_ANSEL2: begin
					nxt_ansel2 = wByte;
				end
				`PPC_OFF_DIR: begin
					nxt_dir = wByte;
				end
				`PPC_OFF_LATCH, `PPC_OFF_PINS: begin
					nxt_latch = wByte;
				end
				default: begin
				end
			endcase
		end
	end

	// Register state, frozen while clock enable is low
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			odc1_ff <= `PPC_RST_BYTE;
		end else if (clkEn) begin
			odc1_ff <= nxt_odc1;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			odc2_ff <= `PPC_RST_BYTE;
		end else if (clkEn) begin
			odc2_ff <= nxt_odc2;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			odc3_ff <= `PPC_RST_BYTE;
		end else if (clkEn) begin
			odc3_ff <= nxt_odc3;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			padCfg_ff <= `PPC_RST_BYTE;
		end else if (clkEn) begin
			padCfg_ff <= nxt_padCfg;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			intCtl2_ff <= `PPC_RST_BYTE;
		end else if (clkEn) begin
			intCtl2_ff <= nxt_intCtl2;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ansel0_ff <= `PPC_RST_ANSEL;
		end else if (clkEn) begin
			ansel0_ff <= nxt_ansel0;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ansel1_ff <= `PPC_RST_ANSEL;
		end else if (clkEn) begin
			ansel1_ff <= nxt_ansel1;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			ansel2_ff <= `PPC_RST_ANSEL;
		end else if (clkEn) begin
			ansel2_ff <= nxt_ansel2;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			dir_ff <= `PPC_RST_DIR;
		end else if (clkEn) begin
			dir_ff <= nxt_dir;
		end
	end

	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			latch_ff <= `PPC_RST_BYTE;
		end else if (clkEn) begin
			latch_ff <= nxt_latch;
		end
	end

	// Read mux
	always @* begin
		nxt_prdata = `PPC_RST_WORD;
		case (paddr)
			`PPC_OFF_ODC1: nxt_prdata[7:0] = odc1_ff;
			`PPC_OFF_ODC2: nxt_prdata[7:0] = odc2_ff;
			`PPC_OFF_ODC3: nxt_prdata[7:0] = odc3_ff;
			`PPC_OFF_PADCFG: nxt_prdata[7:0] = padCfg_ff;
			`PPC_OFF_INTCTL2: nxt_prdata[7:0] = intCtl2_ff;
			`PPC_OFF_ANSEL0: nxt_prdata[7:0] = ansel0_ff;
			`PPC_OFF_ANSEL1: nxt_prdata[7:0] = ansel1_ff;
			`PPC_OFF_ANSEL2: nxt_prdata[7:0] = ansel2_ff;
			`PPC_OFF_DIR: nxt_prdata[7:0] = dir_ff;
			`PPC_OFF_LATCH: nxt_prdata[7:0] = latch_ff;
			`PPC_OFF_PINS: nxt_prdata[7:0] = portPinIn;
			default: nxt_prdata = `PPC_RST_WORD;
		endcase
	end

	// Read data registered at setup, valid in access
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prdata <= `PPC_RST_WORD;
		end else if (clkEn && psel && !penable && !pwrite) begin
			prdata <= nxt_prdata;
		end else if (rdEn) begin
			prdata <= prdata;
		end
	end

	// Pull-up enables, one per port
	assign portBPullup = intCtl2_ff[`PPC_INT2_PUB];
	assign portDPullup = padCfg_ff[`PPC_PAD_PUD];
	assign portEPullup = padCfg_ff[`PPC_PAD_PUE];
	assign portJPullup = padCfg_ff[`PPC_PAD_PUJ];

	// Open-drain peripheral outputs
	assign ccOdEn = {odc2_ff, odc1_ff[`PPC_ODC1_CC2], odc1_ff[`PPC_ODC1_CC1]};
	assign spi1PadOut   = spi1Out & ~odc1_ff[`PPC_ODC1_SPI1];
	assign spi1PadOe    = odOe(odc1_ff[`PPC_ODC1_SPI1], spi1Out);
	assign spi2PadOut   = spi2Out & ~odc1_ff[`PPC_ODC1_SPI2];
	assign spi2PadOe    = odOe(odc1_ff[`PPC_ODC1_SPI2], spi2Out);
	assign capCmpPadOut = capCmpOut & ~ccOdEn;
	assign capCmpPadOe  = ~(ccOdEn & capCmpOut);
	assign ser1PadOut   = ser1Out & ~odc3_ff[`PPC_ODC3_SER1];
	assign ser1PadOe    = odOe(odc3_ff[`PPC_ODC3_SER1], ser1Out);
	assign ser2PadOut   = ser2Out & ~odc3_ff[`PPC_ODC3_SER2];
	assign ser2PadOe    = odOe(odc3_ff[`PPC_ODC3_SER2], ser2Out);

	// Pulse-delay input gate
	assign pulseDelayIn = portFPin1In & odc3_ff[`PPC_ODC3_PDLY];

	assign analogSelect = {ansel2_ff, ansel1_ff, ansel0_ff};

	// Generic port pads
	ppc_pad_cell uPort (
		.dirIn      (dir_ff),
		.latchOut   (latch_ff),
		.odEnable   (`PPC_RST_BYTE),
		.pullEnable (portBPullup),
		.padOut     (portPadOut),
		.padOe      (portPadOe),
		.padPullup  (portPadPullup)
	);
endmodule
`default_nettype wire

// *** common/ppc_regs.vh ***
// Register offsets, field positions and reset values of the pad configuration block
`ifndef PPC_REGS_VH
`define PPC_REGS_VH

`define PPC_ADDR_W        12
`define PPC_OFF_ODC1      12'h000
`define PPC_OFF_ODC2      12'h004
`define PPC_OFF_ODC3      12'h008
`define PPC_OFF_PADCFG    12'h00C
`define PPC_OFF_INTCTL2   12'h010
`define PPC_OFF_ANSEL0    12'h014
`define PPC_OFF_ANSEL1    12'h018
`define PPC_OFF_ANSEL2    12'h01C
`define PPC_OFF_DIR       12'h020
`define PPC_OFF_LATCH     12'h024
`define PPC_OFF_PINS      12'h028

`define PPC_ODC1_MASK     8'hE1
`define PPC_ODC2_MASK     8'hFF
`define PPC_ODC2_MASK32K  8'h3F
`define PPC_ODC3_MASK     8'hC1
`define PPC_PADCFG_MASK   8'hE0
`define PPC_INTCTL2_MASK  8'h80
`define PPC_BYTE_MASK     8'hFF

`define PPC_ODC1_SPI1     7
`define PPC_ODC1_CC2      6
`define PPC_ODC1_CC1      5
`define PPC_ODC1_SPI2     0
`define PPC_ODC3_SER2     7
`define PPC_ODC3_SER1     6
`define PPC_ODC3_PDLY     0
`define PPC_PAD_PUD       7
`define PPC_PAD_PUE       6
`define PPC_PAD_PUJ       5
`define PPC_INT2_PUB      7

`define PPC_RST_BYTE      8'h00
`define PPC_RST_DIR       8'hFF
`define PPC_RST_ANSEL     8'hFF
`define PPC_RST_WORD      32'h00000000

`endif

// *** core/ppc_pad_cell.v ***
// One port of eight pads: direction, open-drain and pull-up qualification
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_cell (
	// Configuration
	input  wire [7:0] dirIn,
	input  wire [7:0] latchOut,
	input  wire [7:0] odEnable,
	input  wire       pullEnable,
	// Pad side
	output wire [7:0] padOut,
	output wire [7:0] padOe,
	output wire [7:0] padPullup
);
	// Input when direction is 1, else drive latch
	// Open drain only ever drives low
	assign padOut    = latchOut & ~odEnable;
	assign padOe     = ~dirIn & ~(odEnable & latchOut);
	assign padPullup = {8{pullEnable}} & dirIn;
endmodule
`default_nettype wire

// *** verif/ppc_pad_config_properties.sv ***
// Port checks for the pad configuration block
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_config_chk (
	// Clock, reset, bus
	input wire logic        mclk,
	input wire logic        rst_b,
	input wire logic        clkEn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	// Peripheral pads
	input wire logic        spi1Out,
	input wire logic        spi1PadOut,
	input wire logic        spi1PadOe,
	input wire logic        ser1Out,
	input wire logic        ser1PadOut,
	input wire logic        ser1PadOe,
	input wire logic [9:0]  capCmpOut,
	input wire logic [9:0]  capCmpPadOut,
	input wire logic [9:0]  capCmpPadOe,
	input wire logic        portFPin1In,
	input wire logic        pulseDelayIn,
	// Pull-ups
	input wire logic        portBPullup,
	input wire logic        portDPullup,
	input wire logic        portEPullup,
	input wire logic        portJPullup,
	input wire logic [7:0]  portPadOe,
	input wire logic [7:0]  portPadPullup
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	AST_SPI1_REL: assert property (!spi1PadOe |-> spi1Out && !spi1PadOut)
		else $error("spi1 pad released while low");
	AST_SER1_HIGH: assert property (ser1PadOut |-> ser1PadOe && ser1Out)
		else $error("ser1 pad high wrongly");
	AST_CAP_PADS: assert property ((capCmpPadOe | capCmpOut) == 10'h3FF
		&& (capCmpPadOut & ~capCmpOut) == 10'h000) else $error("capture pad wrong");
	AST_PULSE_DLY: assert property (pulseDelayIn |-> portFPin1In)
		else $error("pulse delay without pin");
	AST_PULL_INPUT: assert property ((portPadPullup & portPadOe) == 8'h00)
		else $error("pull-up on output pin");
	AST_PULL_RESET: assert property ($rose(rst_b) |-> !(portBPullup || portDPullup
		|| portEPullup || portJPullup)) else $error("pull-up on after reset");
	AST_PULL_WRITE: assert property ($changed({portBPullup, portDPullup, portEPullup,
		portJPullup}) |-> $past(psel && penable && pwrite)) else $error("pull-up moved");
	AST_READY: assert property (psel && penable |-> pready)
		else $error("access not answered");
	AST_RDATA_TOP: assert property (prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	AST_FREEZE: assert property (!clkEn |=> $stable({portBPullup, portDPullup, portEPullup,
		portJPullup, prdata})) else $error("state moved while frozen");
endmodule
bind ppc_pad_config ppc_pad_config_chk u_chk (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata),
	.spi1Out(spi1Out), .spi1PadOut(spi1PadOut), .spi1PadOe(spi1PadOe), .ser1Out(ser1Out),
	.ser1PadOut(ser1PadOut), .ser1PadOe(ser1PadOe), .capCmpOut(capCmpOut),
	.capCmpPadOut(capCmpPadOut), .capCmpPadOe(capCmpPadOe), .portFPin1In(portFPin1In),
	.pulseDelayIn(pulseDelayIn), .portBPullup(portBPullup), .portDPullup(portDPullup),
	.portEPullup(portEPullup), .portJPullup(portJPullup), .portPadOe(portPadOe),
	.portPadPullup(portPadPullup));
`default_nettype wire

// *** verif/ppc_far_side.sv ***
// Far side: pin levels and board pull-up
`timescale 1ns/1ps
`default_nettype none
module ppc_far_side (
	// Generic port
	input  wire logic [7:0] portPadOut,
	input  wire logic [7:0] portPadOe,
	input  wire logic [7:0] portPadPullup,
	input  wire logic [7:0] extDrive,
	output logic      [7:0] portPinIn,
	// Serial line
	input  wire logic       ser1PadOut,
	input  wire logic       ser1PadOe,
	output logic            ser1Line
);
	// Driven bits, then weak pull-up, else outside logic
	assign portPinIn = (portPadOe & portPadOut) | (~portPadOe & (portPadPullup | extDrive));
	// Board resistor lifts a released line
	assign ser1Line = ser1PadOe ? ser1PadOut : 1'b1;
endmodule
`default_nettype wire

// *** verif/test_ppc_pad_config.sv ***
// Self-checking bench for the pad configuration block
`timescale 1ns/1ps
`default_nettype none
`include "ppc_regs.vh"
module test_ppc_pad_config;
	logic        mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, err, clkEn = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, prdataSmall, rdSmall;
	logic        pready, pslverr, spi1Out = 0, spi2Out = 0, ser1Out = 0, ser2Out = 0;
	logic        portFPin1In = 0, spi1PadOut, spi1PadOe, spi2PadOut, spi2PadOe;
	logic        ser1PadOut, ser1PadOe, ser2PadOut, ser2PadOe, pulseDelayIn, ser1Line;
	logic        portBPullup, portDPullup, portEPullup, portJPullup;
	logic [9:0]  capCmpOut = 0, capCmpPadOut, capCmpPadOe;
	logic [23:0] analogSelect;
	logic [7:0]  portPinIn, portPadOut, portPadOe, portPadPullup, extDrive = 0;
	logic [7:0]  mdl [0:10];
	logic [7:0]  msk [0:10] = '{`PPC_ODC1_MASK, `PPC_ODC2_MASK, `PPC_ODC3_MASK,
		`PPC_PADCFG_MASK, `PPC_INTCTL2_MASK, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	int          bad_count = 0, checks_done = 0;
	always #5 mclk = ~mclk;
	ppc_pad_config u_ppc_pad_config (.clkEn(clkEn), .*);
	ppc_pad_config #(.SMALL_MEMORY(1)) u_ppc_pad_config_small (.clkEn(clkEn),
		.prdata(prdataSmall), .pready(), .pslverr(), .spi1PadOut(), .spi1PadOe(),
		.spi2PadOut(), .spi2PadOe(), .capCmpPadOut(), .capCmpPadOe(), .ser1PadOut(),
		.ser1PadOe(), .ser2PadOut(), .ser2PadOe(), .pulseDelayIn(), .portBPullup(),
		.portDPullup(), .portEPullup(), .portJPullup(), .analogSelect(), .portPadOut(),
		.portPadOe(), .portPadPullup(), .*);
	ppc_far_side u_ppc_far_side (.*);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		rdSmall = prdataSmall;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd_all();
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, 12'(i * 4), 8'h00);
			chk(rd, i < 10 ? mdl[i] : (~mdl[8] & mdl[9]) | (mdl[8] & (mdl[4][7] ? 8'hFF : extDrive)));
			if (i == 1) chk(rdSmall, mdl[1] & `PPC_ODC2_MASK32K);
		end
		apb(1'b0, 12'h02C, 8'h00);
		chk(rd, 32'h0);
		chk(err, 32'h1);
	endtask
	task automatic pad_chk();
		logic [13:0] en, v;
		en = {mdl[2][7], mdl[2][6], mdl[0][0], mdl[0][7], mdl[1], mdl[0][6], mdl[0][5]};
		v = {ser2Out, ser1Out, spi2Out, spi1Out, capCmpOut};
		chk({ser2PadOut, ser1PadOut, spi2PadOut, spi1PadOut, capCmpPadOut}, v & ~en);
		chk({ser2PadOe, ser1PadOe, spi2PadOe, spi1PadOe, capCmpPadOe}, 14'(~(en & v)));
		chk({portBPullup, portDPullup, portEPullup, portJPullup}, {mdl[4][7], mdl[3][7:5]});
		chk(pulseDelayIn, portFPin1In & mdl[2][0]);
		chk(analogSelect, {mdl[7], mdl[6], mdl[5]});
		chk({portPadOe, portPadOut, portPadPullup}, {~mdl[8], mdl[9], mdl[8] & {8{mdl[4][7]}}});
		chk(ser1Line, ser1Out);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#100us;
		bad_count++;
		give_verdict();
	end
	initial begin
		void'($urandom(60));
		mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		rd_all();
		repeat (6) begin
			for (int i = 0; i < 11; i++) begin
				apb(1'b1, 12'(i * 4), 8'($urandom));
				mdl[i == 10 ? 9 : i] = pwdata[7:0] & msk[i];
			end
			apb(1'b1, 12'h02C, 8'hFF);
			chk(err, 32'h1);
			rd_all();
			@(posedge mclk);
			{spi1Out, spi2Out, ser1Out, ser2Out, portFPin1In, capCmpOut} <= 15'($urandom);
			extDrive <= 8'($urandom);
			@(posedge mclk);
			#1;
			pad_chk();
		end
		@(posedge mclk);
		clkEn <= 1'b0;
		apb(1'b1, `PPC_OFF_ODC1, ~mdl[0]);
		clkEn <= 1'b1;
		rd_all();
		@(posedge mclk);
		rst_b <= 1'b0;
		repeat (4) @(posedge mclk);
		rst_b <= 1'b1;
		mdl = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
		rd_all();
		@(posedge mclk);
		#1;
		pad_chk();
		give_verdict();
	end
endmodule
`default_nettype wire
